// [design/baud_cfg.svh]
`ifndef BAUD_CFG_SVH
`define BAUD_CFG_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define BAUD_OFF_TXCTL 32'h0000_0000
`define BAUD_OFF_RXCTL 32'h0000_0004
`define BAUD_OFF_DIV 32'h0000_0008
`define BAUD_OFF_STAT 32'h0000_000C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BAUD_TX_MASTER 7
`define BAUD_TX_SYNC 4
`define BAUD_TX_HSS 2
`define BAUD_TX_EMPTY 1
`define BAUD_RX_ENABLE 7
`define BAUD_TX_WMASK 8'hF5
`define BAUD_RX_WMASK 8'hF8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BAUD_TXCTL_RST 8'h00
`define BAUD_RXCTL_RST 8'h00
`define BAUD_DIV_RST 8'h00

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define BAUD_DIV_WIDTH 8
`define BAUD_RATIO_LOW 64
`define BAUD_RATIO_HIGH 16
`define BAUD_RATIO_SYNC 4

`endif

// [design/baud_pkg.sv]
package baud_pkg;

    // ----------------------------------------------------------------
    // Bus carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } ahb_in_t;

    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } ahb_out_t;

    // ----------------------------------------------------------------
    // Modes and register selects
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_ASYNC_LOW  = 2'b00,
        MODE_ASYNC_HIGH = 2'b01,
        MODE_SYNC       = 2'b10
    } mode_t;

    typedef enum logic [1:0] {
        SEL_TXCTL = 2'b00,
        SEL_RXCTL = 2'b01,
        SEL_DIV   = 2'b10,
        SEL_STAT  = 2'b11
    } reg_sel_t;

endpackage

// [design/rate_timer.sv]
`include "baud_cfg.svh"

module rate_timer #(
    parameter int DIV_W = `BAUD_DIV_WIDTH
) (
    // Clock, reset and freeze
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Control
    input wire logic clear,
    input wire logic [DIV_W-1:0] divisor,
    input wire baud_pkg::mode_t mode,
    // Ticks
    output logic rate_tick,
    output logic bit_tick,
    output logic samp_stb,
    output logic samp_last
);
    import baud_pkg::*;

    logic [DIV_W-1:0] cnt_ff;
    logic [5:0] pre_ff;
    logic rate_tick_ff;
    logic bit_tick_ff;
    logic samp_stb_ff;
    logic samp_last_ff;
    logic tc;
    logic [5:0] top;
    logic [5:0] mid;

    // Last prescaler count for each mode
    function automatic logic [5:0] pre_top(input mode_t m);
        unique case (m)
            MODE_ASYNC_LOW: pre_top = 6'(`BAUD_RATIO_LOW - 1);
            MODE_ASYNC_HIGH: pre_top = 6'(`BAUD_RATIO_HIGH - 1);
            MODE_SYNC: pre_top = 6'(`BAUD_RATIO_SYNC - 1);
            default: pre_top = 6'(`BAUD_RATIO_LOW - 1);
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Divisor timer
    // ----------------------------------------------------------------
    assign tc = (cnt_ff == divisor);
    assign top = pre_top(mode);
    // Seven bits for the sum, or 63 plus one wraps to zero in low speed
    assign mid = 6'((7'(top) + 7'h01) >> 1);

    // Up-counter runs on the device clock only, period divisor plus one
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= '0;
        end else if (ce) begin
            if (clear || tc) begin
                cnt_ff <= '0;
            end else begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end

    // One-cycle pulse per terminal count; a clear swallows it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rate_tick_ff <= 1'b0;
        end else if (ce) begin
            rate_tick_ff <= tc && !clear;
        end
    end

    // ----------------------------------------------------------------
    // Bit prescaler
    // ----------------------------------------------------------------
    // Counts rate ticks; wraps at 64, 16 or 4
    // Wrap on >= so a mode change mid-bit cannot strand the count high
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pre_ff <= 6'h00;
        end else if (ce) begin
            if (clear) begin
                pre_ff <= 6'h00;
            end else if (tc) begin
                pre_ff <= (pre_ff >= top) ? 6'h00 : pre_ff + 6'h01;
            end
        end
    end

    // Bit tick and the three sample strobes around mid-bit
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bit_tick_ff <= 1'b0;
            samp_stb_ff <= 1'b0;
            samp_last_ff <= 1'b0;
        end else if (ce) begin
            bit_tick_ff <= tc && !clear && (pre_ff >= top);
            samp_stb_ff <= tc && !clear &&
                (pre_ff == mid - 6'h01 || pre_ff == mid || pre_ff == mid + 6'h01);
            samp_last_ff <= tc && !clear && (pre_ff == mid + 6'h01);
        end
    end

    assign rate_tick = rate_tick_ff;
    assign bit_tick = bit_tick_ff;
    assign samp_stb = samp_stb_ff;
    assign samp_last = samp_last_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    a_count_bound: assert property (cnt_ff <= divisor)
        else $error("timer count passed divisor");
    a_tick_at_tc: assert property (ce && !clear && tc |=> rate_tick_ff)
        else $error("no rate tick at terminal count");
    a_tick_only_tc: assert property (ce && !(tc && !clear) |=> !rate_tick_ff)
        else $error("rate tick without terminal count");
    a_clear_restart: assert property (ce && clear |=> cnt_ff == '0 && !rate_tick_ff)
        else $error("divisor write did not restart timer");
    a_zero_div: assert property (ce && !clear && divisor == '0 ##1 ce && !clear
        |=> rate_tick_ff)
        else $error("zero divisor must tick every clock");
    a_low_ratio: assert property (ce && !clear && tc && mode == MODE_ASYNC_LOW
        && pre_ff == 6'h3F |=> bit_tick_ff)
        else $error("low speed bit tick missing");
    a_high_ratio: assert property (ce && !clear && tc && mode == MODE_ASYNC_HIGH
        && pre_ff == 6'h0F |=> bit_tick_ff && pre_ff == 6'h00)
        else $error("high speed bit tick missing");
    a_sync_ratio: assert property (ce && !clear && tc && mode == MODE_SYNC
        && pre_ff == 6'h03 |=> bit_tick_ff && pre_ff == 6'h00)
        else $error("synchronous bit tick missing");

endmodule

// [design/serial_baud_rate_generator.sv]
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`include "baud_cfg.svh"

module serial_baud_rate_generator (
    // Clock, reset and freeze
    input wire logic CLK,
    input wire logic NRST,
    input wire logic CE,
    // AHB-Lite slave
    input wire baud_pkg::ahb_in_t AHB_IN,
    output baud_pkg::ahb_out_t AHB_OUT,
    // Serial receive pin
    input wire logic RECEIVE_INPUT_PIN,
    // Ticks and resolved level towards the shifters
    output logic RATE_TICK,
    output logic BIT_TICK,
    output logic RX_LEVEL,
    output logic RX_VALID
);
    import baud_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    ahb_out_t ahb_out_ff;
    logic wr_pend_ff;
    reg_sel_t wr_sel_ff;
    logic [7:0] tx_ff;
    logic [7:0] rx_ff;
    logic [7:0] div_ff;
    logic [7:0] nxt_tx;
    logic [7:0] nxt_rx;
    logic [7:0] nxt_div;
    logic [31:0] nxt_rdata;
    logic rx_s1_ff;
    logic rx_s2_ff;
    logic [1:0] smp_ff;
    logic rx_level_ff;
    logic rx_valid_ff;
    logic addr_ok;
    logic addr_hit;
    reg_sel_t addr_sel;
    logic wr_en;
    logic wr_div;
    logic port_en;
    logic samp_stb;
    logic samp_last;
    logic [7:0] hwdata_lo;
    mode_t mode;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Mode from the control bits; high speed select is ignored when synchronous
    function automatic mode_t mode_of(input logic [7:0] tx);
        if (tx[`BAUD_TX_SYNC]) begin
            mode_of = MODE_SYNC;
        end else if (tx[`BAUD_TX_HSS]) begin
            mode_of = MODE_ASYNC_HIGH;
        end else begin
            mode_of = MODE_ASYNC_LOW;
        end
    endfunction

    // Majority of three samples
    function automatic logic maj3(input logic a, input logic b, input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

    // Register read mux; the transmit-empty bit reads set, no shifter here
    function automatic logic [31:0] reg_read(input reg_sel_t sel, input logic [7:0] tx,
                                             input logic [7:0] rx, input logic [7:0] dv,
                                             input logic lvl, input mode_t md);
        unique case (sel)
            SEL_TXCTL: reg_read = {24'h00_0000, tx | 8'(1 << `BAUD_TX_EMPTY)};
            SEL_RXCTL: reg_read = {24'h00_0000, rx};
            SEL_DIV: reg_read = {24'h00_0000, dv};
            SEL_STAT: reg_read = {29'h0000_0000, md, lvl};
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    assign addr_ok = AHB_IN.hsel && AHB_IN.htrans[1] && AHB_IN.hready;
    assign addr_hit = (AHB_IN.haddr[31:4] == 28'h000_0000);
    assign addr_sel = reg_sel_t'(AHB_IN.haddr[3:2]);

    // Address phase of a mapped write, other than to STAT, is parked for its data phase
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            wr_pend_ff <= 1'b0;
            wr_sel_ff <= SEL_TXCTL;
        end else if (CE) begin
            wr_pend_ff <= addr_ok && AHB_IN.hwrite && addr_hit && addr_sel != SEL_STAT;
            wr_sel_ff <= addr_sel;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    assign wr_en = wr_pend_ff && CE;
    assign wr_div = wr_en && wr_sel_ff == SEL_DIV;
    assign hwdata_lo = AHB_IN.hwdata[7:0];

    // Next values; reads use them so a read right behind a write sees it
    always_comb begin
        nxt_tx = tx_ff;
        nxt_rx = rx_ff;
        nxt_div = div_ff;
        if (wr_en && wr_sel_ff == SEL_TXCTL) begin
            nxt_tx = hwdata_lo & `BAUD_TX_WMASK;
        end
        if (wr_en && wr_sel_ff == SEL_RXCTL) begin
            nxt_rx = hwdata_lo & `BAUD_RX_WMASK;
        end
        if (wr_div) begin
            nxt_div = hwdata_lo;
        end
    end

    // Control and divisor storage
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            tx_ff <= `BAUD_TXCTL_RST;
            rx_ff <= `BAUD_RXCTL_RST;
            div_ff <= `BAUD_DIV_RST;
        end else if (CE) begin
            tx_ff <= nxt_tx;
            rx_ff <= nxt_rx;
            div_ff <= nxt_div;
        end
    end

    assign mode = mode_of(tx_ff);
    assign port_en = rx_ff[`BAUD_RX_ENABLE];

    // ----------------------------------------------------------------
    // Bus response
    // ----------------------------------------------------------------
    // Zero wait states: read data is latched at the address phase
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (addr_ok && !AHB_IN.hwrite && addr_hit) begin
            nxt_rdata = reg_read(addr_sel, nxt_tx, nxt_rx, nxt_div, rx_level_ff, mode);
        end
    end

    // Unmapped reads return zero, unmapped writes vanish; always OKAY
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ahb_out_ff <= '{hreadyout: 1'b1, hresp: 1'b0, hrdata: 32'h0000_0000};
        end else if (CE) begin
            ahb_out_ff.hreadyout <= 1'b1;
            ahb_out_ff.hresp <= 1'b0;
            ahb_out_ff.hrdata <= nxt_rdata;
        end
    end

    assign AHB_OUT = ahb_out_ff;

    // ----------------------------------------------------------------
    // Rate generator
    // ----------------------------------------------------------------
    // A divisor write clears the timer in the same edge that loads it
    rate_timer #(
        .DIV_W(`BAUD_DIV_WIDTH)
    ) u_rate_timer (
        .clk(CLK),
        .nrst(NRST),
        .ce(CE),
        .clear(wr_div),
        .divisor(div_ff),
        .mode(mode),
        .rate_tick(RATE_TICK),
        .bit_tick(BIT_TICK),
        .samp_stb(samp_stb),
        .samp_last(samp_last)
    );

    // ----------------------------------------------------------------
    // Receive sampling
    // ----------------------------------------------------------------
    // Pin is asynchronous: two flops before anything looks at it
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rx_s1_ff <= 1'b1;
            rx_s2_ff <= 1'b1;
        end else if (CE) begin
            rx_s1_ff <= RECEIVE_INPUT_PIN;
            rx_s2_ff <= rx_s1_ff;
        end
    end

    // Three samples per bit, resolved by majority; a lone glitch is outvoted
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            smp_ff <= 2'b11;
            rx_level_ff <= 1'b1;
            rx_valid_ff <= 1'b0;
        end else if (CE) begin
            rx_valid_ff <= 1'b0;
            if (port_en && samp_stb) begin
                smp_ff <= {smp_ff[0], rx_s2_ff};
            end
            if (port_en && samp_last) begin
                rx_level_ff <= maj3(smp_ff[1], smp_ff[0], rx_s2_ff);
                rx_valid_ff <= 1'b1;
            end
        end
    end

    assign RX_LEVEL = rx_level_ff;
    assign RX_VALID = rx_valid_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);

    sequence s_div_write;
        CE && wr_pend_ff && wr_sel_ff == SEL_DIV;
    endsequence

    sequence s_third_sample;
        CE && port_en && samp_last;
    endsequence

    a_div_load: assert property (s_div_write |=> div_ff == $past(hwdata_lo))
        else $error("divisor write not stored");
    a_div_restart: assert property (s_div_write |=> !RATE_TICK)
        else $error("tick survived a divisor write");
    a_majority_vote: assert property (s_third_sample |=> RX_VALID
        && RX_LEVEL == maj3($past(smp_ff[1]), $past(smp_ff[0]), $past(rx_s2_ff)))
        else $error("received level is not the majority");
    a_sync_ignores: assert property (tx_ff[`BAUD_TX_SYNC] |-> mode == MODE_SYNC)
        else $error("high speed select leaked into synchronous mode");

endmodule

// [dv/serial_baud_rate_generator_bench.sv]
`include "baud_cfg.svh"

module serial_baud_rate_generator_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import baud_pkg::*;

    // ----------------------------------------------------------------
    // Signals and scoreboard state
    // ----------------------------------------------------------------
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic rx_pin = 1'b1;
    ahb_in_t bus_q = '0;
    ahb_in_t ahb_in;
    ahb_out_t ahb_out;
    logic rate_tick, bit_tick, rx_level, rx_valid;
    logic [31:0] exp_q[$];
    int rate_q[$];
    int bit_q[$];
    int error_cnt = 0;
    int comparisons = 0;
    int rcnt = 0, bcnt = 0, rx_cnt = 0;
    logic arm = 1'b0, rseen = 1'b0, bseen = 1'b0, rd_pend = 1'b0;
    logic rx_arm = 1'b0, rx_exp = 1'b1;
    logic [31:0] seed = 32'd77209;

    // Single slave, so its ready is the bus ready
    always_comb begin
        ahb_in = bus_q;
        ahb_in.hready = ahb_out.hreadyout;
    end

    serial_baud_rate_generator i_dut (
        .CLK(clk), .NRST(nrst), .CE(ce), .AHB_IN(ahb_in), .AHB_OUT(ahb_out),
        .RECEIVE_INPUT_PIN(rx_pin), .RATE_TICK(rate_tick), .BIT_TICK(bit_tick),
        .RX_LEVEL(rx_level), .RX_VALID(rx_valid)
    );

    initial begin
        forever #5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] step();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One single-word transfer; read data is judged by the monitor
    task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                       input logic [31:0] exp);
        @(posedge clk);
        bus_q.hsel <= 1'b1;
        bus_q.htrans <= 2'b10;
        bus_q.haddr <= addr;
        bus_q.hwrite <= wr;
        bus_q.hsize <= 3'b010;
        if (!wr) exp_q.push_back(exp);
        @(posedge clk);
        while (ahb_out.hreadyout !== 1'b1) @(posedge clk);
        bus_q.hsel <= 1'b0;
        bus_q.htrans <= 2'b00;
        bus_q.hwdata <= wd;
        @(posedge clk);
        while (ahb_out.hreadyout !== 1'b1) @(posedge clk);
    endtask

    task automatic print_verdict();
        $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Monitor: takes the oldest note whenever a result shows up
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        rcnt++;
        bcnt++;
        // Disarmed: forget old ticks so a new setting is never timed from one
        if (!arm) begin
            rseen = 1'b0;
            bseen = 1'b0;
        end
        if (rd_pend && ahb_out.hreadyout === 1'b1) begin
            chk(ahb_out.hrdata, exp_q.pop_front());
            chk({31'h0, ahb_out.hresp}, 32'h0);
            rd_pend = 1'b0;
        end
        if (ce && ahb_in.hsel && ahb_in.htrans[1] && !ahb_in.hwrite && ahb_in.hready)
            rd_pend = 1'b1;
        // First pulse after arming only seeds the interval count
        if (rate_tick === 1'b1) begin
            if (arm && rseen && rate_q.size() > 0) chk(rcnt, rate_q.pop_front());
            rseen = arm;
            rcnt = 0;
        end
        if (bit_tick === 1'b1) begin
            if (arm && bseen && bit_q.size() > 0) chk(bcnt, bit_q.pop_front());
            bseen = arm;
            bcnt = 0;
        end
        if (rx_valid === 1'b1 && rx_arm) begin
            chk(rx_level, rx_exp);
            rx_cnt++;
        end
    end

    // Watchdog: the whole sequence needs under 3k cycles
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    logic [7:0] modes [4] = '{8'h00, 8'h04, 8'h10, 8'h14};
    int ratio [4] = '{`BAUD_RATIO_LOW, `BAUD_RATIO_HIGH, `BAUD_RATIO_SYNC, `BAUD_RATIO_SYNC};
    logic [31:0] mcode [4] = '{32'h0, 32'h1, 32'h2, 32'h2};

    initial begin
        int d, n, r;
        logic [7:0] v;
        logic lvl;
        repeat (12) @(posedge clk);
        chk({rate_tick, bit_tick, rx_valid}, 32'h0);
        nrst <= 1'b1;
        @(posedge clk);

        // Reset values, access kinds, unmapped and read-only places
        ahb(1'b0, `BAUD_OFF_TXCTL, 32'h0, 32'h02);
        ahb(1'b0, `BAUD_OFF_RXCTL, 32'h0, 32'h00);
        ahb(1'b0, `BAUD_OFF_DIV, 32'h0, 32'h00);
        ahb(1'b0, `BAUD_OFF_STAT, 32'h0, 32'h01);
        ahb(1'b1, `BAUD_OFF_TXCTL, 32'hFFFF_FFFF, 32'h0);
        ahb(1'b0, `BAUD_OFF_TXCTL, 32'h0, 32'hF7);
        ahb(1'b1, `BAUD_OFF_RXCTL, 32'hFFFF_FFFF, 32'h0);
        ahb(1'b0, `BAUD_OFF_RXCTL, 32'h0, 32'hF8);
        ahb(1'b1, `BAUD_OFF_RXCTL, 32'h0, 32'h0);
        ahb(1'b1, `BAUD_OFF_TXCTL, 32'h0, 32'h0);
        ahb(1'b1, 32'h0000_0010, 32'hFF, 32'h0);
        ahb(1'b0, 32'h0000_0010, 32'h0, 32'h0);
        ahb(1'b1, `BAUD_OFF_STAT, 32'hFF, 32'h0);
        ahb(1'b0, `BAUD_OFF_STAT, 32'h0, 32'h01);
        v = 8'(step());
        ahb(1'b1, `BAUD_OFF_DIV, {24'h0, v}, 32'h0);
        ahb(1'b0, `BAUD_OFF_DIV, 32'h0, {24'h0, v});
        // Clock enable low: a write must not land
        @(posedge clk);
        ce <= 1'b0;
        ahb(1'b1, `BAUD_OFF_DIV, {24'h0, ~v}, 32'h0);
        ce <= 1'b1;
        ahb(1'b0, `BAUD_OFF_DIV, 32'h0, {24'h0, v});
        $display("test registers done");

        // Tick periods in every mode, divisor zero and a random one
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 2; k++) begin
                d = (k == 0) ? 0 : int'(step() % 4) + 1;
                @(negedge clk) arm = 1'b0;
                ahb(1'b1, `BAUD_OFF_TXCTL, {24'h0, modes[m]}, 32'h0);
                ahb(1'b1, `BAUD_OFF_DIV, d, 32'h0);
                ahb(1'b0, `BAUD_OFF_STAT, 32'h0, (mcode[m] << 1) | 32'h1);
                @(negedge clk) arm = 1'b1;
                rate_q.push_back(d + 1);
                rate_q.push_back(d + 1);
                bit_q.push_back(ratio[m] * (d + 1));
                bit_q.push_back(ratio[m] * (d + 1));
                while (rate_q.size() > 0 || bit_q.size() > 0) @(posedge clk);
            end
        end
        @(negedge clk) arm = 1'b0;
        $display("test tick periods done");

        // A new divisor restarts the timer at once
        ahb(1'b1, `BAUD_OFF_TXCTL, 32'h0, 32'h0);
        ahb(1'b1, `BAUD_OFF_DIV, 32'd200, 32'h0);
        repeat (60) @(posedge clk);
        ahb(1'b1, `BAUD_OFF_DIV, 32'd2, 32'h0);
        n = 0;
        while (rate_tick !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n <= 4), 32'h1);
        $display("test divisor restart done");

        // Majority vote: one short glitch per level can spoil one sample only
        ahb(1'b1, `BAUD_OFF_TXCTL, 32'h10, 32'h0);
        ahb(1'b1, `BAUD_OFF_DIV, 32'd9, 32'h0);
        ahb(1'b1, `BAUD_OFF_RXCTL, 32'h80, 32'h0);
        for (int i = 0; i < 10; i++) begin
            lvl = 1'(step());
            r = int'(step() % 40);
            // Pin moves only on a rising edge
            @(posedge clk);
            rx_pin <= lvl;
            @(negedge clk) rx_exp = lvl;
            repeat (45) @(posedge clk);
            @(negedge clk) rx_arm = 1'b1;
            repeat (r + 1) @(posedge clk);
            rx_pin <= ~lvl;
            repeat (3) @(posedge clk);
            rx_pin <= lvl;
            repeat (52 - r) @(posedge clk);
            @(negedge clk) rx_arm = 1'b0;
        end
        chk(32'(rx_cnt > 0), 32'h1);
        $display("test majority sampling done");
        print_verdict();
    end
endmodule
